/* File: common/qecl_consts.svh */
// register offsets, field positions and reset values of the encoder block
`ifndef QECL_CONSTS_SVH
`define QECL_CONSTS_SVH

// register indices on the plain register port
`define QECL_ADDR_ENC_CTL 4'h0
`define QECL_ADDR_FLT_CTL 4'h1
`define QECL_ADDR_POS_CNT 4'h2
`define QECL_ADDR_MAX_CNT 4'h3

// encoder_control field positions
`define QECL_ENC_CNT_ERR 15
`define QECL_ENC_IDLE_STOP 13
`define QECL_ENC_INDEX 12
`define QECL_ENC_DIR 11
`define QECL_ENC_MODE_HI 10
`define QECL_ENC_MODE_LO 8
`define QECL_ENC_SWAP 7
`define QECL_ENC_DIR_OE 6
`define QECL_ENC_GATE 5
`define QECL_ENC_PS_HI 4
`define QECL_ENC_PS_LO 3
`define QECL_ENC_IDX_RST 2
`define QECL_ENC_TMR_CS 1
`define QECL_ENC_DIR_SRC 0

// input_filter_control field positions
`define QECL_FLT_IMV_HI 10
`define QECL_FLT_IMV_LO 9
`define QECL_FLT_COUNT_ERROR_IRQ_DISABLE 8
`define QECL_FLT_OUT_EN 7
`define QECL_FLT_CK_HI 6
`define QECL_FLT_CK_LO 4

// reset values
`define QECL_RST_CTL 16'h0000
`define QECL_RST_MAX 16'hFFFF

`endif

/* File: common/qecl_pkg.sv */
// types shared by the quadrature encoder block
package qecl_pkg;

    // operating mode codes of encoder_control
    typedef enum logic [2:0] {
        QECL_OFF = 3'h0,
        QECL_TIMER = 3'h1,
        QECL_UNUSED_A = 3'h2,
        QECL_UNUSED_B = 3'h3,
        QECL_X2_INDEX = 3'h4,
        QECL_X2_MATCH = 3'h5,
        QECL_X4_INDEX = 3'h6,
        QECL_X4_MATCH = 3'h7
    } qecl_mode_e;

    typedef logic [15:0] qecl_word_t;

endpackage

/* File: rtl/qecl_top.sv */
// quadrature encoder interface: filters, decoder, position counter, timer
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "qecl_consts.svh"

// How it works
// RL1 - modes 111/110: x4 decode, match or index reset
// RL2 - modes 101/100: x2 decode, match or index reset
// RL3 - 001 timer, 000 off, 011/010 disabled
// RL4 - count error sets bit 15, index modes
// RL5 - status bit shows current index level
// RL6 - direction bit: hardware in encoder, software timer
// RL7 - idle-stop halts module while device idle
// RL8 - phase swap exchanges A and B inputs
// RL9 - direction output enable drives direction pin
// RL10 - gate enable: timer counts only while gated
// RL11 - timer prescale 1, 8, 64, 256
// RL12 - index reset enable gates index resets
// RL13 - timer clock: phase A rising or internal
// RL14 - timer direction from phase B or bit
// RL15 - x4 index match needs B, A states
// RL16 - x2 index match: chosen phase state
// RL17 - count error interrupt disable bit
// RL18 - filter enable routes inputs through filters
// RL19 - filter clock divide 1 to 256
// RL20 - unimplemented bits read zero, reset zero
// RL21 - sixteen bit up/down counter, direction status
// RL22 - x4 steps both phases, x2 phase A
// RL23 - count error: counter off reset point
module qecl_top (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [15:0] RDATA,
    // encoder pins
    input wire logic PHASE_A_IN,
    input wire logic PHASE_B_IN,
    input wire logic INDEX_IN,
    input wire logic TIMER_GATE_IN,
    // device state
    input wire logic IDLE_MODE,
    // direction pin and count error request
    output logic DIR_OUT,
    output logic DIR_OE,
    output logic COUNT_ERR_IRQ
);

    // ****************************************************************
    // functions
    // ****************************************************************

    // filter sample divider: terminal count for codes 000..111
    function automatic logic [7:0] flt_lim(input logic [2:0] code);
        logic [7:0] lim;
        lim = 8'h00;
        unique case (code)
            3'h0: lim = 8'h00;
            3'h1: lim = 8'h01;
            3'h2: lim = 8'h03;
            3'h3: lim = 8'h0F;
            3'h4: lim = 8'h1F;
            3'h5: lim = 8'h3F;
            3'h6: lim = 8'h7F;
            3'h7: lim = 8'hFF;
        endcase
        return lim;
    endfunction

    // timer prescaler terminal count for 1:1, 1:8, 1:64, 1:256
    function automatic logic [7:0] pre_lim(input logic [1:0] code);
        logic [7:0] lim;
        lim = 8'h00;
        unique case (code)
            2'h0: lim = 8'h00;
            2'h1: lim = 8'h07;
            2'h2: lim = 8'h3F;
            2'h3: lim = 8'hFF;
        endcase
        return lim;
    endfunction

    // one counter step, optionally wrapping at the maximum count
    function automatic logic [15:0] step_cnt(input logic [15:0] cnt,
        input logic up, input logic [15:0] max, input logic wrap);
        logic [15:0] res;
        res = cnt;
        if (up) begin
            res = (wrap && cnt == max) ? 16'h0000 : cnt + 16'h0001;
        end else begin
            res = (wrap && cnt == 16'h0000) ? max : cnt - 16'h0001;
        end
        return res;
    endfunction

    // ****************************************************************
    // registers and decode
    // ****************************************************************

    logic [10:0] ctl_lo_ff;
    logic idle_stop_ff;
    logic dir_ff;
    logic cnt_err_ff;
    logic [6:0] flt_ff;
    logic [15:0] pos_ff;
    logic [15:0] max_ff;
    logic [15:0] rdata_ff;
    logic irq_ff;
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic a_raw_prev_ff;
    logic [7:0] fdiv_ff;
    logic [2:0] hist1_ff;
    logic [2:0] hist2_ff;
    logic [2:0] fout_ff;
    logic [2:0] prev_ff;
    logic idx_prev_ff;
    logic [7:0] pre_ff;

    // register port decode
    wire wr_enc = WR_STB && ADDR == `QECL_ADDR_ENC_CTL;
    wire wr_flt = WR_STB && ADDR == `QECL_ADDR_FLT_CTL;
    wire wr_pos = WR_STB && ADDR == `QECL_ADDR_POS_CNT;
    wire wr_max = WR_STB && ADDR == `QECL_ADDR_MAX_CNT;

    // mode decode; unused codes fall out as neither encoder nor timer
    qecl_pkg::qecl_mode_e mode;
    assign mode = qecl_pkg::qecl_mode_e'(ctl_lo_ff[10:8]);
    wire enc_mode = mode[2];                          // [RL1] [RL2]
    wire x4_mode = mode[2] & mode[1];                 // [RL1]
    wire match_mode = mode[2] & mode[0];              // [RL1] [RL2]
    wire idx_mode = mode[2] & ~mode[0];               // [RL12]
    wire tmr_mode = mode == qecl_pkg::QECL_TIMER;     // [RL3]

    // control fields
    wire swap_en = ctl_lo_ff[`QECL_ENC_SWAP];
    wire dir_oe_en = ctl_lo_ff[`QECL_ENC_DIR_OE];
    wire gate_en = ctl_lo_ff[`QECL_ENC_GATE];
    wire [1:0] ps = ctl_lo_ff[`QECL_ENC_PS_HI:`QECL_ENC_PS_LO];
    wire idx_rst_en = ctl_lo_ff[`QECL_ENC_IDX_RST];
    wire tmr_ext = ctl_lo_ff[`QECL_ENC_TMR_CS];
    wire dir_src = ctl_lo_ff[`QECL_ENC_DIR_SRC];
    wire [1:0] imv = flt_ff[6:5];
    wire count_error_irq_disable = flt_ff[4];
    wire flt_en = flt_ff[3];
    wire [2:0] fck = flt_ff[2:0];

    // halting in idle freezes counting, filters and prescaler alike
    wire run = !(IDLE_MODE && idle_stop_ff);          // [RL7]

    // ****************************************************************
    // input conditioning
    // ****************************************************************

    // pins pass two flops; order {gate, index, b, a}
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
        end else begin
            sync1_ff <= {TIMER_GATE_IN, INDEX_IN, PHASE_B_IN, PHASE_A_IN};
            sync2_ff <= sync1_ff;
        end
    end

    // swap ahead of the filters so filtered phases stay in order
    wire a_sw = swap_en ? sync2_ff[1] : sync2_ff[0];  // [RL8]
    wire b_sw = swap_en ? sync2_ff[0] : sync2_ff[1];  // [RL8]
    wire [2:0] raw3 = {sync2_ff[2], b_sw, a_sw};

    // filter: a level passes after three equal samples in a row
    // >= so a smaller divide code takes effect without waiting for a wrap
    wire ftick = run && fdiv_ff >= flt_lim(fck);      // [RL19]
    wire [2:0] agree = ~(raw3 ^ hist1_ff) & ~(raw3 ^ hist2_ff);
    wire [2:0] nxt_fout = (agree & raw3) | (~agree & fout_ff);
    wire [7:0] nxt_fdiv = ftick ? 8'h00 : (run ? fdiv_ff + 8'h01 : fdiv_ff);

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fdiv_ff <= 8'h00;
            hist1_ff <= 3'h0;
            hist2_ff <= 3'h0;
            fout_ff <= 3'h0;
        end else begin
            fdiv_ff <= nxt_fdiv;
            if (ftick) begin
                hist1_ff <= raw3;
                hist2_ff <= hist1_ff;
                fout_ff <= nxt_fout;
            end
        end
    end

    // filtered or raw inputs as chosen by software
    wire [2:0] sel = flt_en ? fout_ff : raw3;         // [RL18]
    wire a_c = sel[0];
    wire b_c = sel[1];
    wire i_c = sel[2];

    // ****************************************************************
    // quadrature decode and index
    // ****************************************************************

    wire a_chg = a_c ^ prev_ff[0];
    wire b_chg = a_c == prev_ff[0] && b_c != prev_ff[1];
    wire enc_step = enc_mode && (x4_mode ? (a_chg || b_chg) : a_chg); // [RL22]
    wire enc_up = a_c ^ prev_ff[1];                   // [RL22]

    // index match condition per decode mode
    wire x4_hit = b_c == imv[1] && a_c == imv[0];     // [RL15]
    wire x2_hit = (imv[1] ? b_c : a_c) == imv[0];     // [RL16]
    wire idx_hit = i_c && (x4_mode ? x4_hit : x2_hit);
    wire idx_evt = idx_hit && !idx_prev_ff;
    wire idx_rst = idx_mode && idx_rst_en && idx_evt; // [RL12]

    // a match away from zero or the maximum count is a count error
    wire err_set = run && idx_mode && idx_evt &&
        pos_ff != 16'h0000 && pos_ff != max_ff;       // [RL4] [RL23]

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            prev_ff <= 3'h0;
            idx_prev_ff <= 1'b0;
            a_raw_prev_ff <= 1'b0;
        end else if (run) begin
            prev_ff <= sel;
            idx_prev_ff <= idx_hit;
            a_raw_prev_ff <= sync2_ff[0];
        end
    end

    // ****************************************************************
    // timer path
    // ****************************************************************

    // external clock is the unswapped phase A pin, rising edge
    wire src_tick = tmr_ext ? (sync2_ff[0] && !a_raw_prev_ff) : 1'b1; // [RL13]
    wire gate_ok = !gate_en || sync2_ff[3];           // [RL10]
    wire pre_tick = run && tmr_mode && src_tick && gate_ok;
    // >= so lowering the prescale never stalls the timer until a wrap
    wire pre_end = pre_ff >= pre_lim(ps);             // [RL11]
    wire tmr_step = pre_tick && pre_end;
    wire tmr_up = dir_src ? sync2_ff[1] : dir_ff;     // [RL14]
    wire [7:0] nxt_pre = !tmr_mode ? 8'h00 :
        (pre_tick ? (pre_end ? 8'h00 : pre_ff + 8'h01) : pre_ff);

    // ****************************************************************
    // position counter
    // ****************************************************************

    wire do_step = run && (enc_step || tmr_step);
    wire step_up = enc_mode ? enc_up : tmr_up;
    wire wrap = match_mode || tmr_mode;
    logic [15:0] nxt_pos;
    always_comb begin
        nxt_pos = pos_ff;
        if (wr_pos) begin
            nxt_pos = WDATA;
        end else if (run && idx_rst) begin
            nxt_pos = 16'h0000;                       // [RL12]
        end else if (do_step) begin
            nxt_pos = step_cnt(pos_ff, step_up, max_ff, wrap); // [RL21]
        end
    end

    // direction: tracked by decoder, or software/pin in timer mode
    logic nxt_dir;
    always_comb begin
        nxt_dir = dir_ff;
        if (enc_mode && run && enc_step) begin
            nxt_dir = enc_up;                         // [RL6] [RL21]
        end else if (tmr_mode && dir_src) begin
            nxt_dir = sync2_ff[1];                    // [RL14]
        end else if (tmr_mode && wr_enc) begin
            nxt_dir = WDATA[`QECL_ENC_DIR];           // [RL6]
        end
    end

    // a hardware set beats a software clear in the same cycle
    wire nxt_err = err_set ||
        (wr_enc ? WDATA[`QECL_ENC_CNT_ERR] : cnt_err_ff); // [RL4]

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pos_ff <= 16'h0000;
            max_ff <= `QECL_RST_MAX;
            pre_ff <= 8'h00;
            dir_ff <= 1'b0;
            cnt_err_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            pos_ff <= nxt_pos;
            max_ff <= wr_max ? WDATA : max_ff;
            pre_ff <= nxt_pre;
            dir_ff <= nxt_dir;
            cnt_err_ff <= nxt_err;
            irq_ff <= err_set && !count_error_irq_disable;               // [RL17]
        end
    end

    // ****************************************************************
    // control registers and read port
    // ****************************************************************

    // implemented control bits all reset to zero
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_lo_ff <= 11'h000;                     // [RL20]
            idle_stop_ff <= 1'b0;
            flt_ff <= 7'h00;
        end else begin
            if (wr_enc) begin
                ctl_lo_ff <= WDATA[10:0];
                idle_stop_ff <= WDATA[`QECL_ENC_IDLE_STOP];
            end
            if (wr_flt) begin
                flt_ff <= WDATA[`QECL_FLT_IMV_HI:`QECL_FLT_CK_LO];
            end
        end
    end

    // read mux; unimplemented bits and unmapped addresses give zero
    wire [15:0] enc_rd = {cnt_err_ff, 1'b0, idle_stop_ff, i_c,
        dir_ff, ctl_lo_ff};                           // [RL5] [RL20]
    wire [15:0] flt_rd = {5'h00, flt_ff, 4'h0};      // [RL20]
    wire [15:0] rd_mux =
        ADDR == `QECL_ADDR_ENC_CTL ? enc_rd :
        ADDR == `QECL_ADDR_FLT_CTL ? flt_rd :
        ADDR == `QECL_ADDR_POS_CNT ? pos_ff :
        ADDR == `QECL_ADDR_MAX_CNT ? max_ff : 16'h0000;

    // data stand only in the cycle after the read strobe
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= RD_STB ? rd_mux : 16'h0000;
        end
    end

    assign RDATA = rdata_ff;
    assign DIR_OUT = dir_ff;                          // [RL9]
    assign DIR_OE = dir_oe_en;                        // [RL9]
    assign COUNT_ERR_IRQ = irq_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_rd_enc;
        RD_STB && ADDR == `QECL_ADDR_ENC_CTL;
    endsequence

    sequence s_no_pos_wr;
        !wr_pos;
    endsequence

    a_err_flag_set: assert property (err_set |=> cnt_err_ff) // [RL4] [RL23]
        else $error("count error not flagged");
    a_unused_hold: assert property ( // [RL3]
        (!enc_mode && !tmr_mode) ##0 s_no_pos_wr |=> $stable(pos_ff))
        else $error("counter moved while disabled");
    a_idle_halt: assert property ( // [RL7]
        (IDLE_MODE && idle_stop_ff) ##0 s_no_pos_wr |=> $stable(pos_ff))
        else $error("counter moved in idle stop");
    a_dir_pin_out: assert property ( // [RL9]
        DIR_OE == dir_oe_en && DIR_OUT == dir_ff)
        else $error("direction pin mismatch");
    a_dir_follow: assert property ( // [RL6] [RL21]
        enc_mode && run && enc_step |=> DIR_OUT == $past(enc_up))
        else $error("direction status not updated");
    a_irq_masked: assert property (COUNT_ERR_IRQ |-> !$past(count_error_irq_disable)) // [RL17]
        else $error("interrupt raised while disabled");
    a_rsvd_zero: assert property (s_rd_enc |=> RDATA[14] == 1'b0) // [RL20]
        else $error("reserved bit read nonzero");
    a_index_level: assert property ( // [RL5]
        s_rd_enc |=> RDATA[12] == $past(i_c))
        else $error("index status wrong");
    a_match_wrap: assert property ( // [RL1] [RL2]
        match_mode && run && enc_step && enc_up && pos_ff == max_ff
        && !wr_pos |=> pos_ff == 16'h0000)
        else $error("no wrap at maximum count");
    a_x2_b_only: assert property ( // [RL22]
        mode[2] && !mode[1] && !a_chg && !idx_rst && !wr_pos
        |=> $stable(pos_ff))
        else $error("x2 counted without phase A edge");
    a_gate_hold: assert property ( // [RL10]
        tmr_mode && gate_en && !sync2_ff[3] && !wr_pos
        |=> $stable(pos_ff) [*1])
        else $error("timer counted with gate low");

endmodule

/* File: testbench/qecl_encoder_model.sv */
// behavioural incremental encoder driving the phase and index pins
`timescale 1ns/10ps
module qecl_encoder_model (
    // clock and requests from the bench
    input wire logic clk,
    input wire logic step,
    input wire logic up,
    input wire logic index_req,
    // encoder pins
    output logic phase_a,
    output logic phase_b,
    output logic index
);
    logic [1:0] ph_ff = 2'h0;

    // one quarter cycle per request, forwards or backwards
    always @(posedge clk) begin
        if (step) begin
            ph_ff <= up ? ph_ff + 2'h1 : ph_ff - 2'h1;
        end
    end

    // gray order 00,10,11,01: a leads b when turning up
    assign phase_a = (ph_ff == 2'h1) || (ph_ff == 2'h2);
    assign phase_b = ph_ff[1];
    // index stays high as long as the bench asks, a real disc is wider
    assign index = index_req;
endmodule

/* File: testbench/quadrature_encoder_control_bench.sv */
// self-checking bench of the quadrature encoder block
`timescale 1ns/10ps
`include "qecl_consts.svh"
module quadrature_encoder_control_bench;
    logic REF_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000;
    logic WR_STB = 1'b0;
    logic RD_STB = 1'b0;
    logic TIMER_GATE_IN = 1'b0;
    logic IDLE_MODE = 1'b0;
    logic step = 1'b0;
    logic dir_up = 1'b0;
    logic idx_req = 1'b0;
    logic pa, pb, pi;
    logic [15:0] RDATA;
    logic DIR_OUT, DIR_OE, COUNT_ERR_IRQ;
    logic [15:0] rdat;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int irq_count = 0;
    logic [2:0] off_modes [3] = '{3'h0, 3'h2, 3'h3};
    int pre_div [4] = '{1, 8, 64, 256};

    qecl_top i_qecl_top (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
        .PHASE_A_IN(pa), .PHASE_B_IN(pb), .INDEX_IN(pi),
        .TIMER_GATE_IN(TIMER_GATE_IN), .IDLE_MODE(IDLE_MODE),
        .DIR_OUT(DIR_OUT), .DIR_OE(DIR_OE), .COUNT_ERR_IRQ(COUNT_ERR_IRQ));
    qecl_encoder_model i_qecl_encoder_model (.clk(REF_CLK), .step(step),
        .up(dir_up), .index_req(idx_req), .phase_a(pa), .phase_b(pb),
        .index(pi));

    // ****************************************
    // clock, watchdog and shared tasks
    // ****************************************
    always #4 REF_CLK = ~REF_CLK;

    // watchdog and request counter look mid-cycle, clear of the edge
    always @(negedge REF_CLK) begin
        cycles++;
        if (COUNT_ERR_IRQ === 1'b1) irq_count++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize;
        if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        @(posedge REF_CLK);
        WR_STB <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe is taken
    task automatic rd(input logic [3:0] a);
        @(posedge REF_CLK);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge REF_CLK);
        RD_STB <= 1'b0;
        #1 rdat = RDATA;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        rd(a);
        check(rdat, e);
    endtask

    // spacing leaves room for sync and the fastest filter setting
    task automatic steps(input int n, input logic u);
        repeat (n) begin
            @(posedge REF_CLK);
            step <= 1'b1;
            dir_up <= u;
            @(posedge REF_CLK);
            step <= 1'b0;
            repeat (8) @(posedge REF_CLK);
        end
        #1;
    endtask

    task automatic in_range(input logic [15:0] lo, input logic [15:0] hi);
        check({15'h0000, rdat >= lo && rdat <= hi}, 16'h0001);
    endtask

    // index pin held high for eight cycles
    task automatic idx_pulse;
        idx_req <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        idx_req <= 1'b0;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge REF_CLK);
        RST_N <= 1'b1;
        check({15'h0000, DIR_OE}, 16'h0000);
        rchk(`QECL_ADDR_ENC_CTL, 16'h0000);
        rchk(`QECL_ADDR_FLT_CTL, 16'h0000);
        rchk(`QECL_ADDR_MAX_CNT, 16'hFFFF);
        rchk(4'hF, 16'h0000);
        wr(`QECL_ADDR_FLT_CTL, 16'hFFFF);
        rchk(`QECL_ADDR_FLT_CTL, 16'h07F0);
        wr(`QECL_ADDR_FLT_CTL, 16'h0000);
        wr(`QECL_ADDR_ENC_CTL, 16'h5000);
        rchk(`QECL_ADDR_ENC_CTL, 16'h0000);
        // x4 with match reset: every edge of both phases counts
        wr(`QECL_ADDR_ENC_CTL, 16'h0700);
        steps(4, 1'b1);
        rchk(`QECL_ADDR_POS_CNT, 16'h0004);
        rchk(`QECL_ADDR_ENC_CTL, 16'h0F00);
        steps(2, 1'b0);
        rchk(`QECL_ADDR_POS_CNT, 16'h0002);
        wr(`QECL_ADDR_MAX_CNT, 16'h0005);
        wr(`QECL_ADDR_POS_CNT, 16'h0004);
        steps(2, 1'b1);
        rchk(`QECL_ADDR_POS_CNT, 16'h0000);
        wr(`QECL_ADDR_MAX_CNT, 16'hFFFF);
        // x2: only phase a edges count
        wr(`QECL_ADDR_POS_CNT, 16'h0000);
        wr(`QECL_ADDR_ENC_CTL, 16'h0500);
        steps(4, 1'b1);
        rchk(`QECL_ADDR_POS_CNT, 16'h0002);
        // swapped phases turn the count round
        wr(`QECL_ADDR_ENC_CTL, 16'h0780);
        wr(`QECL_ADDR_POS_CNT, 16'h000A);
        steps(2, 1'b1);
        rchk(`QECL_ADDR_POS_CNT, 16'h0008);
        foreach (off_modes[i]) begin
            wr(`QECL_ADDR_ENC_CTL, {5'h00, off_modes[i], 8'h00});
            wr(`QECL_ADDR_POS_CNT, 16'h0003);
            steps(2, 1'b1);
            rchk(`QECL_ADDR_POS_CNT, 16'h0003);
        end
        // idle stop halts, clearing it resumes while still idle; a full
        // cycle leaves the pins where the halted decoder last saw them
        wr(`QECL_ADDR_ENC_CTL, 16'h2700);
        wr(`QECL_ADDR_POS_CNT, 16'h0000);
        IDLE_MODE <= 1'b1;
        steps(4, 1'b1);
        rchk(`QECL_ADDR_POS_CNT, 16'h0000);
        wr(`QECL_ADDR_ENC_CTL, 16'h0740);
        steps(1, 1'b1);
        rchk(`QECL_ADDR_POS_CNT, 16'h0001);
        check({14'h0000, DIR_OE, DIR_OUT}, 16'h0003);
        steps(1, 1'b0);
        check({15'h0000, DIR_OUT}, 16'h0000);
        IDLE_MODE <= 1'b0;
        // filters: fast setting passes steps, slowest one holds them back
        wr(`QECL_ADDR_FLT_CTL, 16'h0080);
        repeat (20) @(posedge REF_CLK);
        wr(`QECL_ADDR_POS_CNT, 16'h0000);
        steps(2, 1'b1);
        rchk(`QECL_ADDR_POS_CNT, 16'h0002);
        wr(`QECL_ADDR_FLT_CTL, 16'h00F0);
        steps(1, 1'b1);
        rchk(`QECL_ADDR_POS_CNT, 16'h0002);
        repeat (1100) @(posedge REF_CLK);
        rchk(`QECL_ADDR_POS_CNT, 16'h0003);
        wr(`QECL_ADDR_FLT_CTL, 16'h0000);
        // timer on the internal clock, direction bit set by software
        wr(`QECL_ADDR_ENC_CTL, 16'h0100);
        wr(`QECL_ADDR_ENC_CTL, 16'h0900);
        rchk(`QECL_ADDR_ENC_CTL, 16'h0900);
        for (int i = 0; i < 4; i++) begin
            wr(`QECL_ADDR_ENC_CTL, 16'h0900 | (16'(i) << 3));
            wr(`QECL_ADDR_POS_CNT, 16'h0000);
            repeat (10 * pre_div[i]) begin
                @(posedge REF_CLK);
            end
            rd(`QECL_ADDR_POS_CNT);
            in_range(16'h0009, 16'h000D);
        end
        // gated timer only counts while the gate is high
        wr(`QECL_ADDR_ENC_CTL, 16'h0920);
        wr(`QECL_ADDR_POS_CNT, 16'h0000);
        repeat (20) @(posedge REF_CLK);
        rchk(`QECL_ADDR_POS_CNT, 16'h0000);
        TIMER_GATE_IN <= 1'b1;
        repeat (20) @(posedge REF_CLK);
        rd(`QECL_ADDR_POS_CNT);
        in_range(16'h0010, 16'h0018);
        TIMER_GATE_IN <= 1'b0;
        // external clock: one phase a rising edge per full cycle
        wr(`QECL_ADDR_ENC_CTL, 16'h0902);
        wr(`QECL_ADDR_POS_CNT, 16'h0000);
        steps(4, 1'b1);
        rchk(`QECL_ADDR_POS_CNT, 16'h0001);
        // index reset in x4: a wrong phase state is no match
        wr(`QECL_ADDR_ENC_CTL, 16'h0604);
        wr(`QECL_ADDR_FLT_CTL, {5'h00, ~pb, ~pa, 9'h000});
        wr(`QECL_ADDR_POS_CNT, 16'h0004);
        idx_req <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        idx_req <= 1'b0;
        rchk(`QECL_ADDR_POS_CNT, 16'h0004);
        wr(`QECL_ADDR_FLT_CTL, {5'h00, pb, pa, 9'h000});
        idx_req <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        rd(`QECL_ADDR_ENC_CTL);
        check(rdat & 16'hF7FF, 16'h9604);
        idx_req <= 1'b0;
        rchk(`QECL_ADDR_POS_CNT, 16'h0000);
        check(16'(irq_count), 16'h0001);
        // no reset without the enable, no request while disabled
        wr(`QECL_ADDR_ENC_CTL, 16'h0600);
        wr(`QECL_ADDR_FLT_CTL, {5'h00, pb, pa, 9'h100});
        wr(`QECL_ADDR_POS_CNT, 16'h0004);
        idx_req <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        idx_req <= 1'b0;
        rchk(`QECL_ADDR_POS_CNT, 16'h0004);
        rd(`QECL_ADDR_ENC_CTL);
        check(rdat & 16'h8000, 16'h8000);
        check(16'(irq_count), 16'h0001);
        // x2 index reset: the chosen phase b must be in the given state
        wr(`QECL_ADDR_ENC_CTL, 16'h0404);
        wr(`QECL_ADDR_FLT_CTL, {5'h00, 1'b1, ~pb, 9'h000});
        wr(`QECL_ADDR_POS_CNT, 16'h0004);
        idx_pulse();
        rchk(`QECL_ADDR_POS_CNT, 16'h0004);
        wr(`QECL_ADDR_FLT_CTL, {5'h00, 1'b1, pb, 9'h000});
        idx_pulse();
        rchk(`QECL_ADDR_POS_CNT, 16'h0000);
        check(16'(irq_count), 16'h0002);
        // timer direction taken from the phase b pin, here low
        wr(`QECL_ADDR_ENC_CTL, 16'h0101);
        steps(2, 1'b0);
        wr(`QECL_ADDR_POS_CNT, 16'h0100);
        repeat (10) @(posedge REF_CLK);
        rd(`QECL_ADDR_POS_CNT);
        in_range(16'h00F3, 16'h00F7);
        rchk(`QECL_ADDR_ENC_CTL, 16'h0101);
        summarize();
    end
endmodule
